// *** pixel_fix_control_registers.sv ***
// Control and status register bank of the defective-pixel correction core.
`timescale 1ns/1ps
module pixel_fix_control_registers #(
   parameter bit HAS_REG_PORT = 1'b1,
   parameter bit DEBUG_EN = 1'b1,
   // Identity fields; the values are arbitrary.
   parameter logic [7:0] ID_REVISION = 8'h01,
   parameter logic [3:0] ID_FIX_LEVEL = 4'h0,
   parameter logic [3:0] ID_SUB_RELEASE = 4'h0,
   parameter logic [7:0] ID_MINOR = 8'h00,
   parameter logic [7:0] ID_MAJOR = 8'h01
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic s_axi_aclken_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [31:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   input wire logic frame_start_i,
   input wire logic frame_end_i,
   input wire logic line_end_i,
   input wire logic pixel_done_i,
   input wire logic [3:0] framing_fault_i,
   input wire logic [31:0] candidates_i,
   input wire logic [31:0] corrected_i,
   output logic core_run_o,
   output logic core_reset_o,
   output logic bypass_o,
   output logic test_pattern_o,
   output logic [12:0] active_pixels_o,
   output logic [12:0] active_lines_o,
   output logic [11:0] temporal_tolerance_o,
   output logic [15:0] spatial_tolerance_o,
   output logic [15:0] persistence_frames_o,
   output logic irq_o
);

   localparam int FW = pixfix_regs_pkg::FLAG_W;
   localparam int EW = pixfix_regs_pkg::FAULT_W;
   localparam int SW = pixfix_regs_pkg::SIZE_W;
   localparam int TW = pixfix_regs_pkg::TEMPORAL_W;
   localparam int PW = pixfix_regs_pkg::SPATIAL_W;
   localparam int AW = pixfix_regs_pkg::AGE_W;
   localparam logic RUN_DEFAULT = !HAS_REG_PORT;

   // Bus handshake state.
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;

   // Control and settings state.
   logic run_r;
   logic commit_r;
   logic bypass_r;
   logic pattern_r;
   logic fsync_r;
   logic soft_r;
   logic [16:0] mask_r;
   logic [SW-1:0] cpu_pixels_r;
   logic [SW-1:0] cpu_lines_r;
   logic [TW-1:0] cpu_temporal_r;
   logic [PW-1:0] cpu_spatial_r;
   logic [AW-1:0] cpu_age_r;
   logic [SW-1:0] act_pixels_r;
   logic [SW-1:0] act_lines_r;
   logic [TW-1:0] act_temporal_r;
   logic [PW-1:0] act_spatial_r;
   logic [AW-1:0] act_age_r;
   logic [31:0] cand_r;
   logic [31:0] corr_r;
   logic frame_active_r;
   logic core_reset_r;
   logic irq_r;

   // Write path decode.
   wire bus_en = s_axi_aclken_i;
   wire wr_fire = bus_en && awready_r && wready_r;
   wire wr_go = wr_fire && HAS_REG_PORT;
   wire [11:0] wr_ofs = {s_axi_awaddr_i[11:2], 2'b00};
   wire [31:0] wd = s_axi_wdata_i;
   wire wr_ctl = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_CORE_CONTROL);
   wire wr_evt = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_EVENT_FLAGS);
   wire wr_flt = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_FRAMING_FAULTS);
   wire wr_msk = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_INTERRUPT_MASK);
   wire wr_dim = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_FRAME_DIMENSIONS);
   wire wr_tmp = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_TEMPORAL_TOLERANCE);
   wire wr_spa = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_SPATIAL_TOLERANCE);
   wire wr_age = wr_go && (wr_ofs == pixfix_regs_pkg::OFS_PERSISTENCE_FRAMES);

   // The immediate reset wipes flags, counters, settings and statistics, but not the control word or interrupt mask, while the bit stays set.
   wire soft_wipe = soft_r;

   // A frame-synchronised reset fires at frame end, or at once between frames.
   wire fsync_fire = fsync_r && (!frame_active_r || frame_end_i);
   wire core_wipe = soft_wipe || fsync_fire;

   // Settings move to the active set only at frame end with commit set.
   wire commit_now = frame_end_i && commit_r;

   // Event sources.
   logic [FW-1:0] evt_set;
   logic [FW-1:0] evt_clr;
   logic [FW-1:0] evt_q;
   logic [EW-1:0] flt_q;
   logic [EW-1:0] flt_clr;

   always_comb begin
      evt_set = '0;
      evt_set[pixfix_regs_pkg::FLG_BEGUN] = frame_start_i;
      evt_set[pixfix_regs_pkg::FLG_DONE] = frame_end_i;
      evt_set[pixfix_regs_pkg::FLG_INPUT_ERR] = |framing_fault_i;
      evt_clr = wr_evt ? wd[FW-1:0] : '0;
      flt_clr = wr_flt ? wd[EW-1:0] : '0;
   end

   sticky_flags #(
      .W(FW)
   ) u_event_flags (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .wipe_i(core_wipe),
      .set_i(evt_set),
      .clr_i(evt_clr),
      .flags_o(evt_q)
   );

   sticky_flags #(
      .W(EW)
   ) u_framing_faults (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .wipe_i(core_wipe),
      .set_i(framing_fault_i),
      .clr_i(flt_clr),
      .flags_o(flt_q)
   );

   // Debug throughput counters; they count and read back non-zero only in debug builds.
   logic [31:0] frames_q;
   logic [31:0] lines_q;
   logic [31:0] pixels_q;

   event_counter #(
      .W(32)
   ) u_frame_counter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(core_wipe),
      .inc_i(DEBUG_EN && frame_end_i),
      .count_o(frames_q)
   );

   event_counter #(
      .W(32)
   ) u_line_counter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(core_wipe),
      .inc_i(DEBUG_EN && line_end_i),
      .count_o(lines_q)
   );

   event_counter #(
      .W(32)
   ) u_pixel_counter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(core_wipe),
      .inc_i(DEBUG_EN && pixel_done_i),
      .count_o(pixels_q)
   );

   // Read data selection.
   wire [11:0] rd_ofs = {s_axi_araddr_i[11:2], 2'b00};
   wire [31:0] ctl_word = ({31'h0000_0000, run_r} << pixfix_regs_pkg::CTL_RUN)
      | ({31'h0000_0000, commit_r} << pixfix_regs_pkg::CTL_COMMIT)
      | ({31'h0000_0000, bypass_r} << pixfix_regs_pkg::CTL_BYPASS)
      | ({31'h0000_0000, pattern_r} << pixfix_regs_pkg::CTL_PATTERN)
      | ({31'h0000_0000, fsync_r} << pixfix_regs_pkg::CTL_FSYNC_RST)
      | ({31'h0000_0000, soft_r} << pixfix_regs_pkg::CTL_SOFT_RST);
   wire [31:0] id_word = ({24'h00_0000, ID_REVISION} << pixfix_regs_pkg::ID_REV_LSB)
      | ({28'h000_0000, ID_FIX_LEVEL} << pixfix_regs_pkg::ID_FIX_LSB)
      | ({28'h000_0000, ID_SUB_RELEASE} << pixfix_regs_pkg::ID_SUB_LSB)
      | ({24'h00_0000, ID_MINOR} << pixfix_regs_pkg::ID_MINOR_LSB)
      | ({24'h00_0000, ID_MAJOR} << pixfix_regs_pkg::ID_MAJOR_LSB);
   wire [31:0] dim_word = ({19'h0_0000, cpu_pixels_r} << pixfix_regs_pkg::PIX_LSB)
      | ({19'h0_0000, cpu_lines_r} << pixfix_regs_pkg::LINES_LSB);
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (rd_ofs)
         pixfix_regs_pkg::OFS_CORE_CONTROL: rd_word = ctl_word;
         pixfix_regs_pkg::OFS_EVENT_FLAGS: rd_word = {15'h0000, evt_q};
         pixfix_regs_pkg::OFS_FRAMING_FAULTS: rd_word = {28'h000_0000, flt_q};
         pixfix_regs_pkg::OFS_INTERRUPT_MASK: rd_word = {15'h0000, mask_r};
         pixfix_regs_pkg::OFS_HW_IDENTITY: rd_word = id_word;
         pixfix_regs_pkg::OFS_FRAME_COUNTER: rd_word = DEBUG_EN ? frames_q : '0;
         pixfix_regs_pkg::OFS_LINE_COUNTER: rd_word = DEBUG_EN ? lines_q : '0;
         pixfix_regs_pkg::OFS_PIXEL_COUNTER: rd_word = DEBUG_EN ? pixels_q : '0;
         pixfix_regs_pkg::OFS_FRAME_DIMENSIONS: rd_word = dim_word;
         pixfix_regs_pkg::OFS_TEMPORAL_TOLERANCE: rd_word = {20'h0_0000, cpu_temporal_r};
         pixfix_regs_pkg::OFS_SPATIAL_TOLERANCE: rd_word = {16'h0000, cpu_spatial_r};
         pixfix_regs_pkg::OFS_PERSISTENCE_FRAMES: rd_word = {16'h0000, cpu_age_r};
         pixfix_regs_pkg::OFS_CANDIDATE_COUNT: rd_word = cand_r;
         pixfix_regs_pkg::OFS_CORRECTED_COUNT: rd_word = corr_r;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Write channel: address and data are taken together, one at a time.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
      end else if (bus_en) begin
         awready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r && !awready_r;
         wready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r && !awready_r;
         if (wr_fire) begin
            bvalid_r <= 1'b1;
         end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel: one read outstanding, data held until taken.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (bus_en) begin
         arready_r <= s_axi_arvalid_i && !rvalid_r && !arready_r;
         if (arready_r && s_axi_arvalid_i) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
         end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Control word. Software setting the frame-sync bit wins over its self-clear.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         run_r <= RUN_DEFAULT;
         commit_r <= 1'b0;
         bypass_r <= 1'b0;
         pattern_r <= 1'b0;
         fsync_r <= 1'b0;
         soft_r <= 1'b0;
      end else if (wr_ctl) begin
         run_r <= wd[pixfix_regs_pkg::CTL_RUN];
         commit_r <= wd[pixfix_regs_pkg::CTL_COMMIT];
         bypass_r <= wd[pixfix_regs_pkg::CTL_BYPASS];
         pattern_r <= wd[pixfix_regs_pkg::CTL_PATTERN];
         fsync_r <= wd[pixfix_regs_pkg::CTL_FSYNC_RST];
         soft_r <= wd[pixfix_regs_pkg::CTL_SOFT_RST];
      end else if (fsync_fire) begin
         fsync_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mask_r <= '0;
      end else if (wr_msk) begin
         mask_r <= wd[FW-1:0];
      end
   end

   // Processor copy of the double-buffered settings.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cpu_pixels_r <= pixfix_regs_pkg::DEF_PIXELS;
         cpu_lines_r <= pixfix_regs_pkg::DEF_LINES;
         cpu_temporal_r <= pixfix_regs_pkg::DEF_TEMPORAL;
         cpu_spatial_r <= pixfix_regs_pkg::DEF_SPATIAL;
         cpu_age_r <= pixfix_regs_pkg::DEF_AGE;
      end else if (core_wipe) begin
         cpu_pixels_r <= pixfix_regs_pkg::DEF_PIXELS;
         cpu_lines_r <= pixfix_regs_pkg::DEF_LINES;
         cpu_temporal_r <= pixfix_regs_pkg::DEF_TEMPORAL;
         cpu_spatial_r <= pixfix_regs_pkg::DEF_SPATIAL;
         cpu_age_r <= pixfix_regs_pkg::DEF_AGE;
      end else begin
         if (wr_dim) begin
            cpu_pixels_r <= wd[pixfix_regs_pkg::PIX_LSB +: SW];
            cpu_lines_r <= wd[pixfix_regs_pkg::LINES_LSB +: SW];
         end
         if (wr_tmp) begin
            cpu_temporal_r <= wd[TW-1:0];
         end
         if (wr_spa) begin
            cpu_spatial_r <= wd[PW-1:0];
         end
         if (wr_age) begin
            cpu_age_r <= wd[AW-1:0];
         end
      end
   end

   // Active copy, used by the datapath.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         act_pixels_r <= pixfix_regs_pkg::DEF_PIXELS;
         act_lines_r <= pixfix_regs_pkg::DEF_LINES;
         act_temporal_r <= pixfix_regs_pkg::DEF_TEMPORAL;
         act_spatial_r <= pixfix_regs_pkg::DEF_SPATIAL;
         act_age_r <= pixfix_regs_pkg::DEF_AGE;
      end else if (core_wipe) begin
         act_pixels_r <= pixfix_regs_pkg::DEF_PIXELS;
         act_lines_r <= pixfix_regs_pkg::DEF_LINES;
         act_temporal_r <= pixfix_regs_pkg::DEF_TEMPORAL;
         act_spatial_r <= pixfix_regs_pkg::DEF_SPATIAL;
         act_age_r <= pixfix_regs_pkg::DEF_AGE;
      end else if (commit_now) begin
         act_pixels_r <= cpu_pixels_r;
         act_lines_r <= cpu_lines_r;
         act_temporal_r <= cpu_temporal_r;
         act_spatial_r <= cpu_spatial_r;
         act_age_r <= cpu_age_r;
      end
   end

   // Frame tracking and previous-frame statistics.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         frame_active_r <= 1'b0;
         cand_r <= 32'h0000_0000;
         corr_r <= 32'h0000_0000;
      end else if (core_wipe) begin
         frame_active_r <= 1'b0;
         cand_r <= 32'h0000_0000;
         corr_r <= 32'h0000_0000;
      end else begin
         if (frame_start_i) begin
            frame_active_r <= 1'b1;
         end else if (frame_end_i) begin
            frame_active_r <= 1'b0;
         end
         if (frame_end_i) begin
            cand_r <= candidates_i;
            corr_r <= corrected_i;
         end
      end
   end

   // Core-facing outputs, all registered.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_reset_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         core_reset_r <= core_wipe;
         irq_r <= |(evt_q & mask_r);
      end
   end

   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = pixfix_regs_pkg::RESP_OKAY;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = pixfix_regs_pkg::RESP_OKAY;
   assign core_run_o = run_r;
   assign core_reset_o = core_reset_r;
   assign bypass_o = DEBUG_EN && bypass_r;
   assign test_pattern_o = DEBUG_EN && pattern_r;
   assign active_pixels_o = act_pixels_r;
   assign active_lines_o = act_lines_r;
   assign temporal_tolerance_o = act_temporal_r;
   assign spatial_tolerance_o = act_spatial_r;
   assign persistence_frames_o = act_age_r;
   assign irq_o = irq_r;

endmodule : pixel_fix_control_registers

// *** pixfix_regs_pkg.sv ***
// Register map, field layout and reset constants of the pixel-fix control bank.
package pixfix_regs_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Byte offsets of the registers.
   localparam logic [11:0] OFS_CORE_CONTROL = 12'h000;
   localparam logic [11:0] OFS_EVENT_FLAGS = 12'h004;
   localparam logic [11:0] OFS_FRAMING_FAULTS = 12'h008;
   localparam logic [11:0] OFS_INTERRUPT_MASK = 12'h00C;
   localparam logic [11:0] OFS_HW_IDENTITY = 12'h010;
   localparam logic [11:0] OFS_FRAME_COUNTER = 12'h014;
   localparam logic [11:0] OFS_LINE_COUNTER = 12'h018;
   localparam logic [11:0] OFS_PIXEL_COUNTER = 12'h01C;
   localparam logic [11:0] OFS_FRAME_DIMENSIONS = 12'h020;
   localparam logic [11:0] OFS_TEMPORAL_TOLERANCE = 12'h100;
   localparam logic [11:0] OFS_SPATIAL_TOLERANCE = 12'h104;
   localparam logic [11:0] OFS_PERSISTENCE_FRAMES = 12'h108;
   localparam logic [11:0] OFS_CANDIDATE_COUNT = 12'h10C;
   localparam logic [11:0] OFS_CORRECTED_COUNT = 12'h120;

   // Bit positions in core_control.
   localparam int CTL_RUN = 0;
   localparam int CTL_COMMIT = 1;
   localparam int CTL_BYPASS = 4;
   localparam int CTL_PATTERN = 5;
   localparam int CTL_FSYNC_RST = 30;
   localparam int CTL_SOFT_RST = 31;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;

   // Bit positions in event_flags.
   localparam int FLAG_W = 17;
   localparam int FLG_BEGUN = 0;
   localparam int FLG_DONE = 1;
   localparam int FLG_INPUT_ERR = 16;

   // Bits of framing_faults: line short, line long, frame short, frame long.
   localparam int FAULT_W = 4;

   // Field layout of the hw_identity word.
   localparam int ID_REV_LSB = 0;
   localparam int ID_FIX_LSB = 8;
   localparam int ID_SUB_LSB = 12;
   localparam int ID_MINOR_LSB = 16;
   localparam int ID_MAJOR_LSB = 24;

   // Field layout of double-buffered settings.
   localparam int SIZE_W = 13;
   localparam int PIX_LSB = 0;
   localparam int LINES_LSB = 16;
   localparam int TEMPORAL_W = 12;
   localparam int SPATIAL_W = 16;
   localparam int AGE_W = 16;

   // Build-time defaults of the settings.
   localparam logic [12:0] DEF_PIXELS = 13'h0780;
   localparam logic [12:0] DEF_LINES = 13'h0438;
   localparam logic [11:0] DEF_TEMPORAL = 12'h010;
   localparam logic [15:0] DEF_SPATIAL = 16'h0008;
   localparam logic [15:0] DEF_AGE = 16'h0100;

   localparam logic [1:0] RESP_OKAY = 2'h0;

endpackage : pixfix_regs_pkg

// *** sticky_flags.sv ***
// Sticky event flags with write-one-to-clear, set winning over clear.
`timescale 1ns/1ps
module sticky_flags #(
   parameter int W = 4
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wipe_i,
   input wire logic [W-1:0] set_i,
   input wire logic [W-1:0] clr_i,
   output logic [W-1:0] flags_o
);

   logic [W-1:0] flags_nxt;

   assign flags_nxt = wipe_i ? '0 : ((flags_o & ~clr_i) | set_i);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flags_o <= '0;
      end else begin
         flags_o <= flags_nxt;
      end
   end

endmodule : sticky_flags

// *** event_counter.sv ***
// Free-running event counter with a synchronous clear.
`timescale 1ns/1ps
module event_counter #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   input wire logic inc_i,
   output logic [W-1:0] count_o
);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_o <= '0;
      end else if (clear_i) begin
         count_o <= '0;
      end else if (inc_i) begin
         count_o <= count_o + 1'b1;
      end
   end

endmodule : event_counter

// *** lite_host.sv ***
// Register-bus host model issuing single AXI4-Lite writes and reads.
`timescale 1ns/1ps
module lite_host (
   input wire logic clk_i,
   input wire logic awready_i,
   input wire logic bvalid_i,
   input wire logic arready_i,
   input wire logic rvalid_i,
   input wire logic [31:0] rdata_i,
   output logic awvalid_o,
   output logic wvalid_o,
   output logic [31:0] awaddr_o,
   output logic [31:0] wdata_o,
   output logic bready_o,
   output logic arvalid_o,
   output logic [31:0] araddr_o,
   output logic rready_o
);
   int hangs = 0;
   initial begin
      {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
      {awaddr_o, wdata_o, araddr_o} = {3{32'h0000_0000}};
   end
   // Released address and data lines show the inverse so stale values never pass.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n;
      @(negedge clk_i);
      {awaddr_o, wdata_o, awvalid_o, wvalid_o} = {a, d, 2'b11};
      n = 0;
      do @(posedge clk_i); while (!awready_i && ++n < 50);
      hangs += int'(n >= 50);
      @(negedge clk_i);
      {awaddr_o, wdata_o, awvalid_o, wvalid_o, bready_o} = {~a, ~d, 3'b001};
      n = 0;
      do @(posedge clk_i); while (!bvalid_i && ++n < 50);
      hangs += int'(n >= 50);
      @(negedge clk_i);
      bready_o = 1'b0;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      int n;
      @(negedge clk_i);
      {araddr_o, arvalid_o} = {a, 1'b1};
      n = 0;
      do @(posedge clk_i); while (!arready_i && ++n < 50);
      hangs += int'(n >= 50);
      @(negedge clk_i);
      {araddr_o, arvalid_o, rready_o} = {~a, 2'b01};
      n = 0;
      do @(posedge clk_i); while (!rvalid_i && ++n < 50);
      hangs += int'(n >= 50);
      d = rdata_i;
      @(negedge clk_i);
      rready_o = 1'b0;
   endtask : rd
endmodule : lite_host

// *** pixfix_monitor.sv ***
// Checker of write responses and control outputs of the pixel-fix register bank.
`timescale 1ns/1ps
module pixfix_monitor (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic frame_start_i,
   input wire logic frame_end_i,
   input wire logic core_run_o,
   input wire logic core_reset_o,
   input wire logic bypass_o,
   input wire logic test_pattern_o,
   input wire logic [12:0] active_pixels_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic in_frame_r;
   wire [31:0] d = s_axi_wdata_i;
   wire ctl_wr = s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i
      && s_axi_awaddr_i[11:2] == 10'h000;
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i) in_frame_r <= 1'b0;
      else if (frame_start_i || frame_end_i) in_frame_r <= frame_start_i;
   bresp_okay_a:
      assert property (s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0) else $error("bad bresp");
   run_follows_a:
      assert property (ctl_wr |-> ##2 core_run_o == $past(d[0], 2)) else $error("run wrong");
   bypass_follows_a:
      assert property (ctl_wr |-> ##2 bypass_o == $past(d[4], 2)) else $error("bypass wrong");
   pattern_follows_a:
      assert property (ctl_wr |-> ##2 test_pattern_o == $past(d[5], 2))
         else $error("pattern wrong");
   soft_reset_hold_a:
      assert property (ctl_wr && !d[30] |-> ##2 core_reset_o == $past(d[31], 2))
         else $error("soft reset wrong");
   fsync_idle_fire_a:
      assert property (ctl_wr && d[30] && !d[31] && !in_frame_r && !frame_start_i |->
         ##[2:3] core_reset_o ##1 !core_reset_o) else $error("fsync reset wrong");
   settings_at_end_a:
      assert property ($changed(active_pixels_o) |-> $past(frame_end_i) || core_reset_o)
         else $error("settings changed mid-frame");
   reset_release_a:
      assert property ($rose(reset_n_i) |-> !core_reset_o && !core_run_o)
         else $error("outputs wrong after reset");
endmodule : pixfix_monitor
bind pixel_fix_control_registers pixfix_monitor mon (.clk_i, .reset_n_i, .s_axi_awvalid_i,
   .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wdata_i, .s_axi_bresp_o,
   .s_axi_bvalid_o, .frame_start_i, .frame_end_i, .core_run_o, .core_reset_o, .bypass_o,
   .test_pattern_o, .active_pixels_o);

// *** pixel_fix_control_registers_test.sv ***
// Self-checking bench for the pixel-fix register bank.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end
module pixel_fix_control_registers_test;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic s_axi_aclken_i = 1'b1;
   logic frame_start_i = 1'b0, frame_end_i = 1'b0, line_end_i = 1'b0, pixel_done_i = 1'b0;
   logic [3:0] framing_fault_i = 4'h0;
   logic [31:0] candidates_i = 32'h0000_0000, corrected_i = 32'h0000_0000;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, v;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic core_run_o, core_reset_o, bypass_o, test_pattern_o, irq_o;
   logic [12:0] active_pixels_o, active_lines_o;
   logic [11:0] temporal_tolerance_o;
   logic [15:0] spatial_tolerance_o, persistence_frames_o;
   int fails = 0;
   int check_count = 0;
   typedef struct packed {logic [11:0] a; logic [31:0] e;} row_t;
   localparam logic [31:0] zero = 32'h0000_0000;
   localparam logic [31:0] def_size = {3'h0, pixfix_regs_pkg::DEF_LINES, 3'h0,
      pixfix_regs_pkg::DEF_PIXELS};
   row_t rows [15] = '{'{12'h000, zero}, '{12'h004, zero}, '{12'h008, zero},
      '{12'h00C, zero}, '{12'h010, 32'h072c_635a}, '{12'h014, zero},
      '{12'h018, zero}, '{12'h01C, zero}, '{12'h020, def_size},
      '{12'h100, {20'h0_0000, pixfix_regs_pkg::DEF_TEMPORAL}},
      '{12'h104, {16'h0000, pixfix_regs_pkg::DEF_SPATIAL}},
      '{12'h108, {16'h0000, pixfix_regs_pkg::DEF_AGE}},
      '{12'h10C, zero}, '{12'h120, zero}, '{12'h200, zero}};
   // Identity parameter values are arbitrary.
   pixel_fix_control_registers #(.ID_REVISION(8'h5a), .ID_FIX_LEVEL(4'h3),
      .ID_SUB_RELEASE(4'h6), .ID_MINOR(8'h2c), .ID_MAJOR(8'h07)) DUT (.*);
   lite_host h (.clk_i, .awready_i(s_axi_awready_o), .bvalid_i(s_axi_bvalid_o),
      .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o), .rdata_i(s_axi_rdata_o),
      .awvalid_o(s_axi_awvalid_i), .wvalid_o(s_axi_wvalid_i), .awaddr_o(s_axi_awaddr_i),
      .wdata_o(s_axi_wdata_i), .bready_o(s_axi_bready_i), .arvalid_o(s_axi_arvalid_i),
      .araddr_o(s_axi_araddr_i), .rready_o(s_axi_rready_i));
   always #5 clk_i = ~clk_i;
   task automatic pulse(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask : pulse
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      h.rd({20'h0_0000, a}, v);
      `CHK($sformatf("reg %h", a), e, v)
      `CHK("rresp", 2'h0, s_axi_rresp_o)
   endtask : rchk
   task automatic finish_test;
      fails += h.hangs;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (3) @(negedge clk_i);
      reset_n_i = 1'b1;
      foreach (rows[i]) rchk(rows[i].a, rows[i].e);
      h.wr(32'h0000_0024, 32'hffff_ffff);
      rchk(12'h024, zero);
      $display("test reset values done");
      {candidates_i, corrected_i} = {32'h1234_5678, 32'h0000_0abc};
      h.wr(32'h0000_0000, 32'h0000_0031);
      `CHK("run", 1'b1, core_run_o)
      `CHK("bypass", 1'b1, bypass_o)
      `CHK("pattern", 1'b1, test_pattern_o)
      h.wr(32'h0000_0020, 32'h0040_0080);
      h.wr(32'h0000_0100, 32'h0000_0123);
      h.wr(32'h0000_0104, 32'h0000_4567);
      h.wr(32'h0000_0108, 32'h0000_89ab);
      pulse(frame_end_i);
      `CHK("pixels", pixfix_regs_pkg::DEF_PIXELS, active_pixels_o)
      h.wr(32'h0000_0000, 32'h0000_0003);
      pulse(frame_end_i);
      `CHK("pixels", 13'h0080, active_pixels_o)
      `CHK("lines", 13'h0040, active_lines_o)
      `CHK("temporal", 12'h123, temporal_tolerance_o)
      `CHK("spatial", 16'h4567, spatial_tolerance_o)
      `CHK("persistence", 16'h89ab, persistence_frames_o)
      rchk(12'h10C, 32'h1234_5678);
      rchk(12'h120, 32'h0000_0abc);
      $display("test commit done");
      pulse(frame_start_i);
      @(negedge clk_i);
      framing_fault_i = 4'h5;
      @(negedge clk_i);
      framing_fault_i = 4'h0;
      rchk(12'h008, 32'h0000_0005);
      rchk(12'h004, 32'h0001_0003);
      h.wr(32'h0000_000C, 32'h0000_0001);
      `CHK("irq", 1'b1, irq_o)
      h.wr(32'h0000_0004, 32'h0000_0001);
      rchk(12'h004, 32'h0001_0002);
      `CHK("irq", 1'b0, irq_o)
      pulse(line_end_i);
      pulse(pixel_done_i);
      rchk(12'h014, 32'h0000_0002);
      rchk(12'h018, 32'h0000_0001);
      rchk(12'h01C, 32'h0000_0001);
      h.wr(32'h0000_0000, zero);
      `CHK("run", 1'b0, core_run_o)
      $display("test flags done");
      h.wr(32'h0000_0000, 32'h8000_0000);
      `CHK("core reset", 1'b1, core_reset_o)
      `CHK("pixels", pixfix_regs_pkg::DEF_PIXELS, active_pixels_o)
      rchk(12'h020, def_size);
      rchk(12'h008, zero);
      h.wr(32'h0000_0000, zero);
      `CHK("core reset", 1'b0, core_reset_o)
      pulse(frame_start_i);
      h.wr(32'h0000_0000, 32'h4000_0000);
      `CHK("core reset", 1'b0, core_reset_o)
      rchk(12'h000, 32'h4000_0000);
      pulse(frame_end_i);
      `CHK("core reset", 1'b1, core_reset_o)
      rchk(12'h000, zero);
      h.wr(32'h0000_0000, 32'h4000_0000);
      rchk(12'h000, zero);
      $display("test resets done");
      finish_test();
   end
endmodule : pixel_fix_control_registers_test
